// file: verilog/dual_fifo_pkg.sv
// Shared constants and types of the dual nine-bit FIFO and its driving agent
package dual_fifo_pkg;
	localparam int CHAN_COUNT = 2;
	localparam int WORD_W = 9;
	localparam int DEPTH_DEFAULT = 256;
	localparam int OFFSET_W = 8;
	localparam int OFFSET_REGS = 4;
	localparam logic [1:0] SEL_EMPTY_LSB = 2'h0;
	localparam logic [1:0] SEL_EMPTY_MSB = 2'h1;
	localparam logic [1:0] SEL_FULL_LSB = 2'h2;
	localparam logic [1:0] SEL_FULL_MSB = 2'h3;
	localparam logic [7:0] EMPTY_OFFSET_LSB_RESET = 8'h07;
	localparam logic [7:0] EMPTY_OFFSET_MSB_RESET = 8'h00;
	localparam logic [7:0] FULL_OFFSET_LSB_RESET = 8'h07;
	localparam logic [7:0] FULL_OFFSET_MSB_RESET = 8'h00;
	localparam logic [8:0] WORD_RESET = 9'h000;
	typedef enum logic {MODE_OFFSET_LOAD, MODE_DUAL_WRITE} wen_mode_t;
endpackage

// file: verilog/dual_fifo_link_if.sv
// Pin bundle between the dual FIFO and its writing and reading agents
`timescale 1ns/1ns
interface dual_fifo_link_if;
	logic [1:0] write_clock;
	logic [1:0] read_clock;
	logic [1:0] chan_reset_n;
	logic [1:0] write_enable_one_n;
	logic [1:0] write_enable_two_load;
	logic [1:0] read_enable_one_n;
	logic [1:0] read_enable_two_n;
	logic [1:0][8:0] write_data;
	logic [1:0][8:0] read_data;
	logic [1:0] full_flag_n;
	logic [1:0] empty_flag_n;
	logic [1:0] almost_full_flag_n;
	logic [1:0] almost_empty_flag_n;

	modport device (
		input write_clock, read_clock, chan_reset_n, write_enable_one_n,
		input write_enable_two_load, read_enable_one_n, read_enable_two_n, write_data,
		output read_data, full_flag_n, empty_flag_n, almost_full_flag_n, almost_empty_flag_n
	);
	modport host (
		output write_clock, read_clock, chan_reset_n, write_enable_one_n,
		output write_enable_two_load, read_enable_one_n, read_enable_two_n, write_data,
		input read_data, full_flag_n, empty_flag_n, almost_full_flag_n, almost_empty_flag_n
	);
endinterface

// file: verilog/dual_fifo_device.sv
// Two independent FIFOs with full, empty and programmable almost flags
`timescale 1ns/1ns
// Behaviour
// - Full flag low at depth; blocks writes
// - Full flag updates on write clock only
// - Empty flag low at zero; blocks reads
// - Empty flag updates on read clock only
// - Four registered flags per FIFO
// - Almost-empty low up to offset n, default 7
// - Almost-full low from depth minus m, default 7
// - Depth parameter 256 to 8192 words
// - Offsets read back in same rotating order
// - Load pin low at reset: offset load control
// - Agent may tie second read enable low
// - Width expansion: shared controls, composite end flags
// - Width expansion: almost flags from one FIFO
// - The two FIFOs run independently, both directions
// - Load pin high at reset: second write enable
// - Dual write mode keeps default offsets
// - Expansion logic steers one enable per port
// - Offset writes rotate through four registers
// - Channel reset empties FIFO, clears outputs
// - Read enables low: next word each read edge
// - Dual mode stores on enable one low, two high
module dual_fifo_device #(
	parameter int DEPTH = dual_fifo_pkg::DEPTH_DEFAULT
) (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	// FIFO pins
	dual_fifo_link_if.device link,
	// Configuration seen at the last channel reset
	output logic [1:0] dual_write_mode_out
);
	localparam int AW = $clog2(DEPTH);

	genvar ch;
	generate
		for (ch = 0; ch < dual_fifo_pkg::CHAN_COUNT; ch++)
		begin : chan
			logic wclk_prev_reg, wclk_prev_next;
			logic rclk_prev_reg, rclk_prev_next;
			logic [AW:0] wptr_reg, wptr_next;
			logic [AW:0] rptr_reg, rptr_next;
			logic [AW:0] count_next;
			logic [1:0] sel_reg, sel_next;
			logic [3:0][7:0] ofs_reg, ofs_next;
			logic [8:0] q_reg, q_next;
			logic full_reg, full_next;
			logic empty_reg, empty_next;
			logic afull_reg, afull_next;
			logic aempty_reg, aempty_next;
			dual_fifo_pkg::wen_mode_t mode_reg, mode_next;
			logic [8:0] mem_reg [DEPTH];
			logic wedge, redge, chan_rst, load_mode, ld_low;
			logic ofs_wr, ofs_rd, mem_wr, mem_rd;
			logic [15:0] empty_ofs, full_ofs;

			always_comb
			begin
				chan_rst = sys_rst_in | ~link.chan_reset_n[ch];
				wedge = link.write_clock[ch] & ~wclk_prev_reg;
				redge = link.read_clock[ch] & ~rclk_prev_reg;
				load_mode = (mode_reg == dual_fifo_pkg::MODE_OFFSET_LOAD);
				ld_low = ~link.write_enable_two_load[ch];
				ofs_wr = wedge & load_mode & ld_low & ~link.write_enable_one_n[ch];
				// In both modes the dual pin must be high for a data write
				mem_wr = wedge & ~link.write_enable_one_n[ch] & ~ld_low & full_reg;
				ofs_rd = redge & load_mode & ld_low & ~link.read_enable_one_n[ch]
					& ~link.read_enable_two_n[ch];
				mem_rd = redge & ~ofs_rd & ~link.read_enable_one_n[ch]
					& ~link.read_enable_two_n[ch] & empty_reg;
				wptr_next = wptr_reg + (AW + 1)'(mem_wr);
				rptr_next = rptr_reg + (AW + 1)'(mem_rd);
				count_next = wptr_next - rptr_next;
				empty_ofs = {ofs_reg[dual_fifo_pkg::SEL_EMPTY_MSB], ofs_reg[dual_fifo_pkg::SEL_EMPTY_LSB]};
				full_ofs = {ofs_reg[dual_fifo_pkg::SEL_FULL_MSB], ofs_reg[dual_fifo_pkg::SEL_FULL_LSB]};
				wclk_prev_next = link.write_clock[ch];
				rclk_prev_next = link.read_clock[ch];
				sel_next = sel_reg + 2'((ofs_wr | ofs_rd) ? 1 : 0);
				ofs_next = ofs_reg;
				if (ofs_wr)
				begin
					ofs_next[sel_reg] = link.write_data[ch][7:0];
				end
				q_next = q_reg;
				if (ofs_rd)
				begin
					q_next = {1'b0, ofs_reg[sel_reg]};
				end
				else if (mem_rd)
				begin
					q_next = mem_reg[rptr_reg[AW-1:0]];
				end
				// Flags move only on their own port's edge, so they may lag the other side
				full_next = wedge ? (count_next != (AW + 1)'(DEPTH)) : full_reg;
				afull_next = wedge ? ((int'(count_next) + int'(full_ofs)) < DEPTH)
					: afull_reg;
				empty_next = redge ? (count_next != '0) : empty_reg;
				aempty_next = redge ? (int'(count_next) > int'(empty_ofs)) : aempty_reg;
				mode_next = mode_reg;
				if (chan_rst)
				begin
					wptr_next = '0;
					rptr_next = '0;
					sel_next = dual_fifo_pkg::SEL_EMPTY_LSB;
					ofs_next[dual_fifo_pkg::SEL_EMPTY_LSB] = dual_fifo_pkg::EMPTY_OFFSET_LSB_RESET;
					ofs_next[dual_fifo_pkg::SEL_EMPTY_MSB] = dual_fifo_pkg::EMPTY_OFFSET_MSB_RESET;
					ofs_next[dual_fifo_pkg::SEL_FULL_LSB] = dual_fifo_pkg::FULL_OFFSET_LSB_RESET;
					ofs_next[dual_fifo_pkg::SEL_FULL_MSB] = dual_fifo_pkg::FULL_OFFSET_MSB_RESET;
					q_next = dual_fifo_pkg::WORD_RESET;
					full_next = 1'b1;
					afull_next = 1'b1;
					empty_next = 1'b0;
					aempty_next = 1'b0;
					// The strap is taken on every channel reset cycle outside system reset; the last one before release counts
					if (sys_rst_in)
					begin
						mode_next = dual_fifo_pkg::MODE_OFFSET_LOAD;
					end
					else if (link.write_enable_two_load[ch])
					begin
						mode_next = dual_fifo_pkg::MODE_DUAL_WRITE;
					end
					else
					begin
						mode_next = dual_fifo_pkg::MODE_OFFSET_LOAD;
					end
				end
			end

			// Each channel owns its whole state; nothing crosses between channels
			always_ff @(posedge ref_clk_in)
			begin
				wclk_prev_reg <= wclk_prev_next;
				rclk_prev_reg <= rclk_prev_next;
				wptr_reg <= wptr_next;
				rptr_reg <= rptr_next;
				sel_reg <= sel_next;
				ofs_reg <= ofs_next;
				q_reg <= q_next;
				full_reg <= full_next;
				afull_reg <= afull_next;
				empty_reg <= empty_next;
				aempty_reg <= aempty_next;
				mode_reg <= mode_next;
				if (mem_wr && !chan_rst)
				begin
					mem_reg[wptr_reg[AW-1:0]] <= link.write_data[ch];
				end
			end

			assign link.read_data[ch] = q_reg;
			assign link.full_flag_n[ch] = full_reg;
			assign link.empty_flag_n[ch] = empty_reg;
			assign link.almost_full_flag_n[ch] = afull_reg;
			assign link.almost_empty_flag_n[ch] = aempty_reg;
			assign dual_write_mode_out[ch] = (mode_reg == dual_fifo_pkg::MODE_DUAL_WRITE);
		end
	endgenerate
endmodule

// file: verilog/dual_fifo_host.sv
// Writing and reading agent that drives both FIFO ports and builds composite flags
`timescale 1ns/1ns
module dual_fifo_host (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	// Per-channel requests; hold until accepted
	input wire logic [1:0] chan_reset_req_in,
	input wire logic [1:0] dual_write_strap_in,
	input wire logic [1:0] expander_select_in,
	input wire logic [1:0] write_req_in,
	input wire logic [1:0] write_load_in,
	input wire logic [1:0][8:0] write_word_in,
	input wire logic [1:0] read_req_in,
	input wire logic [1:0] read_load_in,
	// Answers
	output logic [1:0] write_accept_out,
	output logic [1:0] read_accept_out,
	output logic [1:0] read_valid_out,
	output logic [1:0][8:0] read_word_out,
	output logic composite_empty_n_out,
	output logic composite_full_n_out,
	output logic almost_empty_n_out,
	output logic almost_full_n_out,
	// FIFO pins
	dual_fifo_link_if.host link
);
	logic cempty_reg, cempty_next;
	logic cfull_reg, cfull_next;
	logic aempty_reg, aempty_next;
	logic afull_reg, afull_next;

	always_comb
	begin
		cempty_next = &link.empty_flag_n;
		cfull_next = &link.full_flag_n;
		aempty_next = link.almost_empty_flag_n[0];
		afull_next = link.almost_full_flag_n[0];
	end

	always_ff @(posedge ref_clk_in)
	begin
		cempty_reg <= cempty_next;
		cfull_reg <= cfull_next;
		aempty_reg <= aempty_next;
		afull_reg <= afull_next;
	end

	assign composite_empty_n_out = cempty_reg;
	assign composite_full_n_out = cfull_reg;
	assign almost_empty_n_out = aempty_reg;
	assign almost_full_n_out = afull_reg;

	genvar ch;
	generate
		for (ch = 0; ch < dual_fifo_pkg::CHAN_COUNT; ch++)
		begin : chan
			logic clk_reg, clk_next;
			logic rst_n_reg, rst_n_next;
			logic wen1_reg, wen1_next;
			logic wen2_reg, wen2_next;
			logic read_enable_one_reg, read_enable_one_next;
			logic [8:0] wdata_reg, wdata_next;
			logic wacc_reg, wacc_next;
			logic racc_reg, racc_next;
			logic pend_reg, pend_next;
			logic valid_reg, valid_next;
			logic [8:0] word_reg, word_next;
			logic rising, do_wr, do_rd, idle_pin;

			always_comb
			begin
				// Enables change together with the rising half so they are stable at the edge
				rising = ~clk_reg;
				do_wr = rising & write_req_in[ch] & ~chan_reset_req_in[ch];
				do_rd = rising & read_req_in[ch] & ~chan_reset_req_in[ch];
				// Dual mode: the pin is the expansion steer, else it idles high as load off
				idle_pin = dual_write_strap_in[ch] ? expander_select_in[ch] : 1'b1;
				clk_next = ~clk_reg;
				rst_n_next = ~chan_reset_req_in[ch];
				wen1_next = ~do_wr;
				wen2_next = idle_pin;
				if (chan_reset_req_in[ch])
				begin
					wen2_next = dual_write_strap_in[ch];
				end
				else if ((do_wr && write_load_in[ch]) || (do_rd && read_load_in[ch]))
				begin
					wen2_next = 1'b0;
				end
				read_enable_one_next = ~do_rd;
				wdata_next = do_wr ? write_word_in[ch] : wdata_reg;
				wacc_next = do_wr;
				racc_next = do_rd;
				pend_next = racc_reg;
				valid_next = pend_reg;
				word_next = pend_reg ? link.read_data[ch] : word_reg;
				if (sys_rst_in)
				begin
					clk_next = 1'b0;
					rst_n_next = 1'b0;
					wen1_next = 1'b1;
					wen2_next = 1'b0;
					read_enable_one_next = 1'b1;
					wdata_next = dual_fifo_pkg::WORD_RESET;
					wacc_next = 1'b0;
					racc_next = 1'b0;
					pend_next = 1'b0;
					valid_next = 1'b0;
					word_next = dual_fifo_pkg::WORD_RESET;
				end
			end

			always_ff @(posedge ref_clk_in)
			begin
				clk_reg <= clk_next;
				rst_n_reg <= rst_n_next;
				wen1_reg <= wen1_next;
				wen2_reg <= wen2_next;
				read_enable_one_reg <= read_enable_one_next;
				wdata_reg <= wdata_next;
				wacc_reg <= wacc_next;
				racc_reg <= racc_next;
				pend_reg <= pend_next;
				valid_reg <= valid_next;
				word_reg <= word_next;
			end

			assign link.write_clock[ch] = clk_reg;
			assign link.read_clock[ch] = clk_reg;
			assign link.chan_reset_n[ch] = rst_n_reg;
			assign link.write_enable_one_n[ch] = wen1_reg;
			assign link.write_enable_two_load[ch] = wen2_reg;
			assign link.read_enable_one_n[ch] = read_enable_one_reg;
			assign link.read_enable_two_n[ch] = 1'b0;
			assign link.write_data[ch] = wdata_reg;
			assign write_accept_out[ch] = wacc_reg;
			assign read_accept_out[ch] = racc_reg;
			assign read_valid_out[ch] = valid_reg;
			assign read_word_out[ch] = word_reg;
		end
	endgenerate
endmodule

// file: testbench/dual_fifo_checker.sv
// Concurrent checks on the pins between the dual FIFO and its agent
`timescale 1ns/1ns
module dual_fifo_checker (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	// FIFO pins
	input wire logic [1:0] write_clock,
	input wire logic [1:0] read_clock,
	input wire logic [1:0] chan_reset_n,
	input wire logic [1:0] read_enable_one_n,
	input wire logic [1:0] write_enable_two_load,
	input wire logic [1:0][8:0] read_data,
	input wire logic [1:0] full_flag_n,
	input wire logic [1:0] empty_flag_n,
	input wire logic [1:0] almost_full_flag_n,
	input wire logic [1:0] almost_empty_flag_n
);
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (sys_rst_in);
	for (genvar c = 0; c < 2; c++)
	begin : g_chan
		// Port clock rose one cycle ago, or a channel reset was applied
		sequence wr_step;
			$past(write_clock[c]) && !$past(write_clock[c], 2) || !$past(chan_reset_n[c]);
		endsequence
		sequence rd_step;
			$past(read_clock[c]) && !$past(read_clock[c], 2) || !$past(chan_reset_n[c]);
		endsequence
		sequence rd_blocked;
			!empty_flag_n[c] && $rose(read_clock[c]) && chan_reset_n[c] && write_enable_two_load[c];
		endsequence
		full_clock_a: assert property (
			$changed({full_flag_n[c], almost_full_flag_n[c]}) |-> wr_step)
			else $error("full side flag moved off a write clock edge");
		empty_clock_a: assert property (
			$changed({empty_flag_n[c], almost_empty_flag_n[c]}) |-> rd_step)
			else $error("empty side flag moved off a read clock edge");
		data_stands_a: assert property ($changed(read_data[c]) |-> rd_step)
			else $error("read data moved off a read clock edge");
		chan_reset_a: assert property (!chan_reset_n[c] |=> !empty_flag_n[c] &&
			!almost_empty_flag_n[c] && full_flag_n[c] && almost_full_flag_n[c] && read_data[c] == 9'h000)
			else $error("channel reset did not empty the FIFO");
		read_block_a: assert property (rd_blocked |=> $stable(read_data[c]))
			else $error("read taken while empty");
		write_block_a: assert property (
			!full_flag_n[c] && $rose(write_clock[c]) && read_enable_one_n[c] && chan_reset_n[c]
			|=> !full_flag_n[c])
			else $error("full flag released without a read");
		empty_order_a: assert property (!empty_flag_n[c] |-> !almost_empty_flag_n[c])
			else $error("almost empty high while empty");
		full_order_a: assert property (!full_flag_n[c] |-> !almost_full_flag_n[c])
			else $error("almost full high while full");
	end
endmodule

// file: testbench/test_dual_sync_fifo_flags.sv
// Self-checking bench for the dual FIFO and its agent joined pin to pin
`timescale 1ns/1ns
module test_dual_sync_fifo_flags;
	logic ref_clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic [1:0] rst_req = 2'h3, strap = 2'h0, xsel = 2'h3, wreq = 2'h0, wld = 2'h0;
	logic [1:0] rreq = 2'h0, rld = 2'h0, wacc, racc, rvalid, mode;
	logic [1:0][8:0] wword = '0;
	logic [1:0][8:0] rword;
	logic ce, cf, ae, af;
	logic [8:0] ofs [4] = '{9'h002, 9'h000, 9'h003, 9'h000};
	int n_fail = 0;
	int n_compared = 0;
	dual_fifo_link_if link();
	always #50 ref_clk_in = ~ref_clk_in;
	dual_fifo_device #(.DEPTH(256)) dual_fifo_device_inst (.ref_clk_in(ref_clk_in),
		.sys_rst_in(sys_rst_in), .link(link), .dual_write_mode_out(mode));
	dual_fifo_host dual_fifo_host_inst (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
		.chan_reset_req_in(rst_req), .dual_write_strap_in(strap), .expander_select_in(xsel),
		.write_req_in(wreq), .write_load_in(wld), .write_word_in(wword), .read_req_in(rreq),
		.read_load_in(rld), .write_accept_out(wacc), .read_accept_out(racc),
		.read_valid_out(rvalid), .read_word_out(rword), .composite_empty_n_out(ce),
		.composite_full_n_out(cf), .almost_empty_n_out(ae), .almost_full_n_out(af), .link(link));
	dual_fifo_checker dual_fifo_checker_inst (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
		.write_clock(link.write_clock), .read_clock(link.read_clock),
		.chan_reset_n(link.chan_reset_n), .read_enable_one_n(link.read_enable_one_n),
		.write_enable_two_load(link.write_enable_two_load), .read_data(link.read_data),
		.full_flag_n(link.full_flag_n), .empty_flag_n(link.empty_flag_n),
		.almost_full_flag_n(link.almost_full_flag_n),
		.almost_empty_flag_n(link.almost_empty_flag_n));
	task automatic cyc(input int k);
		repeat (k) @(posedge ref_clk_in);
		#10;
	endtask
	task automatic chk_w(input string nm, input logic [8:0] e, input logic [8:0] g);
		n_compared++;
		if (g !== e)
		begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_b(input string nm, input logic e, input logic g);
		chk_w(nm, {8'h00, e}, {8'h00, g});
	endtask
	// The agent does not look at flags, so blocked accesses still get accepted
	task automatic wr(input int c, input logic ld, input logic [8:0] w);
		int k;
		cyc(1);
		wreq[c] = 1'b1;
		wld[c] = ld;
		wword[c] = w;
		for (k = 0; k < 8 && wacc[c] !== 1'b1; k++)
			cyc(1);
		wreq[c] = 1'b0;
		chk_b("write accept", 1'b1, wacc[c]);
	endtask
	task automatic rd(input int c, input logic ld, input logic [8:0] e);
		int k;
		cyc(1);
		rreq[c] = 1'b1;
		rld[c] = ld;
		for (k = 0; k < 8 && racc[c] !== 1'b1; k++)
			cyc(1);
		rreq[c] = 1'b0;
		chk_b("read accept", 1'b1, racc[c]);
		for (k = 0; k < 8 && rvalid[c] !== 1'b1; k++)
			cyc(1);
		chk_w("read word", e, rword[c]);
	endtask
	// Flags as full, almost full, almost empty, empty; settle covers the lag of the far port
	task automatic flags(input int c, input logic [3:0] e);
		cyc(4);
		chk_w("flags", {5'h00, e}, {5'h00, link.full_flag_n[c], link.almost_full_flag_n[c],
			link.almost_empty_flag_n[c], link.empty_flag_n[c]});
	endtask
	task automatic chan_rst(input logic [1:0] s);
		rst_req = 2'h3;
		strap = s;
		cyc(4);
		rst_req = 2'h0;
		cyc(4);
	endtask
	initial
	begin
		int i;
		cyc(5);
		sys_rst_in = 1'b0;
		chan_rst(2'h0);
		flags(0, 4'hC);
		flags(1, 4'hC);
		chk_w("agent flags", 9'h00C, {5'h00, cf, af, ae, ce});
		chk_w("mode", 9'h000, {7'h00, mode});
		for (i = 0; i < 4; i++)
			rd(0, 1'b1, (i % 2) ? 9'h000 : 9'h007);
		for (i = 0; i < 4; i++)
			wr(0, 1'b1, ofs[i] | 9'h100);
		for (i = 0; i < 4; i++)
			rd(0, 1'b1, ofs[i]);
		for (i = 0; i < 3; i++)
		begin
			wr(0, 1'b0, 9'h1A0 + i[8:0]);
			wr(1, 1'b0, 9'h050 + i[8:0]);
		end
		flags(0, 4'hF);
		flags(1, 4'hD);
		for (i = 0; i < 3; i++)
		begin
			rd(0, 1'b0, 9'h1A0 + i[8:0]);
			rd(1, 1'b0, 9'h050 + i[8:0]);
		end
		rd(1, 1'b0, 9'h052);
		for (i = 1; i <= 256; i++)
		begin
			wr(0, 1'b0, i[8:0]);
			if (i == 2 || i == 3 || i == 252 || i == 253 || i == 256)
				flags(0, (i == 2) ? 4'hD : (i == 256) ? 4'h3 : (i == 253) ? 4'hB : 4'hF);
		end
		wr(0, 1'b0, 9'h1FF);
		flags(0, 4'h3);
		chk_w("agent flags", 9'h002, {5'h00, cf, af, ae, ce});
		for (i = 1; i <= 257; i++)
			rd(0, 1'b0, (i == 257) ? 9'h100 : i[8:0]);
		flags(0, 4'hC);
		chan_rst(2'h2);
		chk_w("mode", 9'h002, {7'h00, mode});
		for (i = 0; i < 8; i++)
		begin
			xsel[1] = (i != 3);
			wr(1, 1'b0, i[8:0]);
		end
		flags(1, 4'hD);
		xsel[1] = 1'b1;
		wr(1, 1'b0, 9'h008);
		flags(1, 4'hF);
		for (i = 0; i < 4; i++)
			rd(1, 1'b0, (i == 3) ? 9'h004 : i[8:0]);
		close_out();
	end
	initial
	begin
		#2000000;
		n_fail++;
		close_out();
	end
	task automatic close_out();
		$display("Compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
endmodule
